// File: logic/timer3_pkg.sv
package timer3_pkg;

  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'h91;
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'h92;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h93;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'h94;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h95;

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int BIT_HIGH_FLAG = 7;
  localparam int BIT_LOW_FLAG = 6;
  localparam int BIT_LOW_IRQ_EN = 5;
  localparam int BIT_CAPTURE_EN = 4;
  localparam int BIT_SPLIT = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_UNUSED = 1;
  localparam int BIT_EXT_CLK = 0;

  // ----------------------------------------
  // Reset values and limits
  // ----------------------------------------
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_RELOAD = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam logic [15:0] WORD_MAX = 16'hFFFF;
  localparam logic [15:0] WORD_ONE = 16'h0001;
  localparam logic [7:0] BYTE_ONE = 8'h01;

  // ----------------------------------------
  // Clock source dividers
  // ----------------------------------------
  localparam int SYS_DIVIDE = 12;
  localparam int EXT_DIVIDE = 8;

endpackage : timer3_pkg

// File: logic/sys_tick_divider.sv
`timescale 1ns/10ps
// Emits a one-cycle tick once every DIVIDE system clocks.
module sys_tick_divider
  import timer3_pkg::*;
#(
  parameter int DIVIDE = SYS_DIVIDE
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Tick
  output logic o_tick
);

  localparam int CW = $clog2(DIVIDE);
  localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);

  typedef struct packed {
    logic [CW-1:0] count;
    logic tick;
  } div_state_t;

  div_state_t r;
  div_state_t n;

  always_comb begin
    n = r;
    n.tick = (r.count == LAST);
    if (r.count == LAST) begin
      n.count = '0;
    end else begin
      n.count = r.count + CW'(1);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign o_tick = r.tick;

endmodule : sys_tick_divider

// File: logic/ext_osc_ticker.sv
`timescale 1ns/10ps
// Synchronises the oscillator pin, divides it by DIVIDE and reports
// the rising and falling edges of the divided clock as pulses.
module ext_osc_ticker
  import timer3_pkg::*;
#(
  parameter int DIVIDE = EXT_DIVIDE
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Oscillator pin
  input wire logic i_ext_osc,
  // Events
  output logic o_rise,
  output logic o_fall
);

  localparam int CW = $clog2(DIVIDE);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
    logic [CW-1:0] count;
    logic rise;
    logic fall;
  } osc_state_t;

  osc_state_t r;
  osc_state_t n;

  // The oscillator must stay below a quarter of the system clock so
  // that no edge is missed after synchronisation.
  always_comb begin
    n = r;
    n.meta = i_ext_osc;
    n.sync = r.meta;
    n.prev = r.sync;
    n.rise = 1'b0;
    n.fall = 1'b0;
    if (r.sync && !r.prev) begin
      n.count = r.count + CW'(1);
      n.rise = (r.count == CW'(DIVIDE / 2 - 1));
      n.fall = (r.count == CW'(DIVIDE - 1));
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign o_rise = r.rise;
  assign o_fall = r.fall;

endmodule : ext_osc_ticker

// File: logic/timer3_reload_capture.sv
`timescale 1ns/10ps
module timer3_reload_capture
  import timer3_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Special function register port
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  // Shared clock control bits and interrupt enable
  input wire logic i_high_byte_clock_select,
  input wire logic i_low_byte_clock_select,
  input wire logic i_timer_irq_enable,
  // External oscillator pin
  input wire logic i_ext_osc,
  // Interrupt request
  output logic o_timer_irq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic high_overflow_flag;
    logic low_overflow_flag;
    logic low_overflow_irq_enable;
    logic capture_mode_enable;
    logic split_mode_enable;
    logic run_control;
    logic external_clock_select;
    logic [7:0] reload_low;
    logic [7:0] reload_high;
    logic [7:0] count_low;
    logic [7:0] count_high;
    logic [7:0] rdata;
    logic irq;
  } tmr_state_t;

  tmr_state_t r;
  tmr_state_t n;

  logic div12_tick;
  logic ext_tick;
  logic capture_event;
  logic src_tick;
  logic tick_low;
  logic tick_high;
  logic set_high;
  logic set_low;
  logic [15:0] count_word;
  logic [15:0] count_inc;
  logic wr_control;
  logic wr_count_low;
  logic wr_count_high;
  logic wr_reload_low;
  logic wr_reload_high;
  logic [7:0] control_view;

  // ----------------------------------------
  // Clock sources
  // ----------------------------------------
  sys_tick_divider #(
    .DIVIDE(SYS_DIVIDE)
  ) u_div12 (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .o_tick(div12_tick)
  );

  ext_osc_ticker #(
    .DIVIDE(EXT_DIVIDE)
  ) u_ext (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_ext_osc(i_ext_osc),
    .o_rise(ext_tick),
    .o_fall(capture_event)
  );

  assign src_tick = r.external_clock_select ? ext_tick : div12_tick;
  assign tick_low = i_low_byte_clock_select | src_tick;
  assign tick_high = i_high_byte_clock_select | src_tick;

  assign count_word = {r.count_high, r.count_low};
  assign count_inc = count_word + WORD_ONE;

  assign wr_control = i_sfr_wr && (i_sfr_addr == ADDR_CONTROL);
  assign wr_reload_low = i_sfr_wr && (i_sfr_addr == ADDR_RELOAD_LOW);
  assign wr_reload_high = i_sfr_wr && (i_sfr_addr == ADDR_RELOAD_HIGH);
  assign wr_count_low = i_sfr_wr && (i_sfr_addr == ADDR_COUNT_LOW);
  assign wr_count_high = i_sfr_wr && (i_sfr_addr == ADDR_COUNT_HIGH);

  assign control_view = {r.high_overflow_flag, r.low_overflow_flag,
                         r.low_overflow_irq_enable, r.capture_mode_enable,
                         r.split_mode_enable, r.run_control, 1'b0,
                         r.external_clock_select};

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n = r;
    set_high = 1'b0;
    set_low = 1'b0;
    if (r.split_mode_enable) begin
      if (tick_low) begin
        if (r.count_low == BYTE_MAX) begin
          n.count_low = r.reload_low;
          set_low = 1'b1;
        end else begin
          n.count_low = r.count_low + BYTE_ONE;
        end
      end
      if (r.run_control && tick_high) begin
        if (r.count_high == BYTE_MAX) begin
          n.count_high = r.reload_high;
          set_high = 1'b1;
        end else begin
          n.count_high = r.count_high + BYTE_ONE;
        end
      end
    end else if (r.run_control && tick_low) begin
      {n.count_high, n.count_low} = count_inc;
      set_low = (r.count_low == BYTE_MAX);
      if (count_word == WORD_MAX) begin
        // Capture mode keeps the captured reload intact, so it wraps.
        if (!r.capture_mode_enable) begin
          {n.count_high, n.count_low} = {r.reload_high, r.reload_low};
          set_high = 1'b1;
        end
      end
    end

    if (wr_count_low) begin
      n.count_low = i_sfr_wdata;
    end
    if (wr_count_high) begin
      n.count_high = i_sfr_wdata;
    end
    if (wr_reload_low) begin
      n.reload_low = i_sfr_wdata;
    end
    if (wr_reload_high) begin
      n.reload_high = i_sfr_wdata;
    end

    if (r.capture_mode_enable && capture_event) begin
      n.reload_high = r.count_high;
      n.reload_low = r.count_low;
      set_high = 1'b1;
    end

    if (wr_control) begin
      n.low_overflow_irq_enable = i_sfr_wdata[BIT_LOW_IRQ_EN];
      n.capture_mode_enable = i_sfr_wdata[BIT_CAPTURE_EN];
      n.split_mode_enable = i_sfr_wdata[BIT_SPLIT];
      n.run_control = i_sfr_wdata[BIT_RUN];
      n.external_clock_select = i_sfr_wdata[BIT_EXT_CLK];
      n.high_overflow_flag = i_sfr_wdata[BIT_HIGH_FLAG] | set_high;
      n.low_overflow_flag = i_sfr_wdata[BIT_LOW_FLAG] | set_low;
    end else begin
      n.high_overflow_flag = r.high_overflow_flag | set_high;
      n.low_overflow_flag = r.low_overflow_flag | set_low;
    end

    unique case (i_sfr_addr)
      ADDR_CONTROL: n.rdata = control_view;
      ADDR_RELOAD_LOW: n.rdata = r.reload_low;
      ADDR_RELOAD_HIGH: n.rdata = r.reload_high;
      ADDR_COUNT_LOW: n.rdata = r.count_low;
      ADDR_COUNT_HIGH: n.rdata = r.count_high;
      default: n.rdata = 8'h00;
    endcase

    n.irq = i_timer_irq_enable &&
            (r.high_overflow_flag ||
             (r.low_overflow_irq_enable && r.low_overflow_flag));
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign o_sfr_rdata = r.rdata;
  assign o_timer_irq = r.irq;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  logic no_count_wr;
  assign no_count_wr = !wr_count_low && !wr_count_high;

  sequence s_full_wrap;
    !r.split_mode_enable && !r.capture_mode_enable && r.run_control &&
    tick_low && (count_word == WORD_MAX) && no_count_wr;
  endsequence

  sequence s_capture;
    r.capture_mode_enable && capture_event && !wr_control;
  endsequence

  sequence s_low_wrap_split;
    r.split_mode_enable && tick_low && (r.count_low == BYTE_MAX) &&
    !wr_count_low && !wr_control;
  endsequence

  chk_full_wrap_reload: assert property (
    s_full_wrap |=> (count_word == {$past(r.reload_high), $past(r.reload_low)}))
    else $error("16-bit wrap did not load reload value");

  chk_full_wrap_flag: assert property (
    s_full_wrap and !wr_control |=> r.high_overflow_flag)
    else $error("16-bit wrap did not set high flag");

  chk_split_low_reload: assert property (
    s_low_wrap_split |=> (r.count_low == $past(r.reload_low)) && r.low_overflow_flag)
    else $error("split low byte did not reload or flag");

  chk_low_free_run: assert property (
    r.split_mode_enable && !r.run_control && tick_low &&
    (r.count_low != BYTE_MAX) && !wr_count_low
    |=> r.count_low == $past(r.count_low) + BYTE_ONE)
    else $error("split low byte stopped without run");

  chk_stopped_hold: assert property (
    !r.run_control && !r.split_mode_enable && no_count_wr
    |=> $stable(count_word))
    else $error("stopped 16-bit timer changed count");

  chk_capture_copy: assert property (
    s_capture and !wr_reload_low |=> (r.reload_low == $past(r.count_low)) &&
    r.high_overflow_flag)
    else $error("capture did not copy count or set flag");

  chk_flags_sticky: assert property (
    (r.high_overflow_flag || r.low_overflow_flag) && !wr_control
    |=> (r.high_overflow_flag >= $past(r.high_overflow_flag)) &&
        (r.low_overflow_flag >= $past(r.low_overflow_flag)))
    else $error("overflow flag cleared without a write");

  chk_irq_high: assert property (
    r.high_overflow_flag && i_timer_irq_enable |=> o_timer_irq)
    else $error("high flag did not raise interrupt");

  chk_irq_low: assert property (
    r.low_overflow_flag && r.low_overflow_irq_enable && i_timer_irq_enable
    |=> o_timer_irq)
    else $error("low flag did not raise interrupt");

  chk_irq_quiet: assert property (
    !i_timer_irq_enable |=> !o_timer_irq)
    else $error("interrupt raised while disabled");

  chk_unused_zero: assert property (
    i_sfr_addr == ADDR_CONTROL |=> !o_sfr_rdata[BIT_UNUSED])
    else $error("unused control bit read as one");

  // ----------------------------------------
  // Counting and register checks
  // ----------------------------------------
  sequence s_high_wrap_split;
    r.split_mode_enable && r.run_control && tick_high && (r.count_high == BYTE_MAX) &&
    !wr_count_high && !wr_control;
  endsequence

  chk_count_step: assert property (
    !r.split_mode_enable && r.run_control && tick_low && (count_word != WORD_MAX) &&
    no_count_wr |=> count_word == $past(count_word) + WORD_ONE)
    else $error("16-bit count did not step by one");

  chk_low_flag_16: assert property (
    !r.split_mode_enable && r.run_control && tick_low && (r.count_low == BYTE_MAX)
    |=> r.low_overflow_flag)
    else $error("16-bit low byte wrap did not set low flag");

  // Software may set the flag by writing one, so writes are left out.
  chk_high_only_wrap: assert property (
    $rose(r.high_overflow_flag) && !$past(wr_control) &&
    !$past(r.split_mode_enable) && !$past(r.capture_mode_enable)
    |-> $past(count_word) == WORD_MAX)
    else $error("high flag set in 16-bit mode without a full wrap");

  chk_split_high_reload: assert property (
    s_high_wrap_split |=> (r.count_high == $past(r.reload_high)) && r.high_overflow_flag)
    else $error("split high byte did not reload or flag");

  chk_high_held_split: assert property (
    r.split_mode_enable && !r.run_control && !wr_count_high |=> $stable(r.count_high))
    else $error("stopped split high byte changed");

  chk_sys_override: assert property (
    r.split_mode_enable && r.run_control && i_high_byte_clock_select &&
    (r.count_high != BYTE_MAX) && !wr_count_high
    |=> r.count_high == $past(r.count_high) + BYTE_ONE)
    else $error("high byte override did not count every clock");

  // Capture wins over a software write of the same byte.
  chk_reload_write: assert property (
    wr_reload_high && !(r.capture_mode_enable && capture_event)
    |=> r.reload_high == $past(i_sfr_wdata))
    else $error("reload high byte write did not land");

  chk_count_read: assert property (
    i_sfr_addr == ADDR_COUNT_HIGH |=> o_sfr_rdata == $past(r.count_high))
    else $error("count high byte read returned wrong value");

  // Eleven idle cycles are written as two repetitions to keep each count small.
  chk_div12_spacing: assert property (
    div12_tick |=> !div12_tick [*8] ##1 !div12_tick [*3] ##1 div12_tick)
    else $error("divided system tick spacing wrong");

endmodule : timer3_reload_capture

// File: sim/testbench.sv
`timescale 1ns/10ps
module testbench;
  import timer3_pkg::*;
  typedef struct {
    logic [7:0] a;
    logic [7:0] w;
    logic [7:0] e;
  } row_t;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_sfr_addr = 8'h00;
  logic i_sfr_wr = 1'b0;
  logic [7:0] i_sfr_wdata = 8'h00;
  logic [7:0] o_sfr_rdata;
  logic i_high_byte_clock_select = 1'b1;
  logic i_low_byte_clock_select = 1'b1;
  logic i_timer_irq_enable = 1'b1;
  logic i_ext_osc = 1'b0;
  logic o_timer_irq;
  logic [7:0] rd_v;
  logic [15:0] cap_a;
  logic [15:0] cap_d;
  int bad_count = 0;
  int cmp_count = 0;
  int osc_cnt = 0;
  row_t rows [8] = '{'{8'h92, 8'hA5, 8'hA5}, '{8'h93, 8'h5A, 8'h5A},
    '{8'h94, 8'h3C, 8'h3C}, '{8'h95, 8'hC3, 8'hC3}, '{8'h91, 8'h22, 8'h20},
    '{8'h91, 8'hC2, 8'hC0}, '{8'h90, 8'h77, 8'h00}, '{8'h91, 8'h00, 8'h00}};

  timer3_reload_capture i_timer3_reload_capture (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_sfr_addr(i_sfr_addr),
    .i_sfr_wr(i_sfr_wr),
    .i_sfr_wdata(i_sfr_wdata),
    .o_sfr_rdata(o_sfr_rdata),
    .i_high_byte_clock_select(i_high_byte_clock_select),
    .i_low_byte_clock_select(i_low_byte_clock_select),
    .i_timer_irq_enable(i_timer_irq_enable),
    .i_ext_osc(i_ext_osc),
    .o_timer_irq(o_timer_irq)
  );

  always #25 i_sys_clk = ~i_sys_clk;

  // Oscillator period is 8 system clocks, so one divided period is 64.
  always @(negedge i_sys_clk) begin
    osc_cnt = (osc_cnt + 1) % 4;
    if (osc_cnt == 0) begin
      i_ext_osc <= ~i_ext_osc;
    end
  end

  // --------------------------------
  // Bus tasks and checks
  // --------------------------------
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_sys_clk);
    i_sfr_addr = a;
    i_sfr_wdata = d;
    i_sfr_wr = 1'b1;
    @(negedge i_sys_clk);
    i_sfr_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(negedge i_sys_clk);
    i_sfr_addr = a;
    @(negedge i_sys_clk);
    rd_v = o_sfr_rdata;
  endtask : rd

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic inr(input logic [7:0] g, input logic [7:0] lo, input logic [7:0] hi);
    cmp_count++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h range %h %h", $time, g, lo, hi);
    end
  endtask : inr

  task automatic poll(input int b);
    int n;
    for (n = 0; n < 400; n++) begin
      rd(ADDR_CONTROL);
      if (rd_v[b] === 1'b1) begin
        break;
      end
    end
    if (n == 400) begin
      bad_count++;
      $display("CHECK FAILED t=%0t flag %0d never set", $time, b);
      finish_test();
    end
  endtask : poll

  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    repeat (8) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_rst = 1'b0;
    for (int a = 8'h91; a <= 8'h95; a++) begin
      rd(8'(a));
      chk(rd_v, 8'h00);
    end
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      chk(rd_v, rows[i].e);
    end
    // Full wrap: both flags, reload, interrupt.
    wr(8'h92, 8'h00);
    wr(8'h93, 8'h12);
    wr(8'h94, 8'hF0);
    wr(8'h95, 8'hFF);
    wr(8'h91, 8'h04);
    poll(7);
    chk(rd_v, 8'hC4);
    chk({7'h00, o_timer_irq}, 8'h01);
    wr(8'h91, 8'h00);
    rd(8'h95);
    chk(rd_v, 8'h12);
    chk({7'h00, o_timer_irq}, 8'h00);
    // Low byte wrap alone must not set the high flag.
    wr(8'h94, 8'hF0);
    wr(8'h95, 8'h00);
    wr(8'h91, 8'h04);
    poll(6);
    wr(8'h91, 8'h40);
    rd(8'h91);
    chk(rd_v, 8'h40);
    chk({7'h00, o_timer_irq}, 8'h00);
    rd(8'h95);
    chk(rd_v, 8'h01);
    wr(8'h91, 8'h60);
    repeat (2) @(negedge i_sys_clk);
    chk({7'h00, o_timer_irq}, 8'h01);
    i_timer_irq_enable = 1'b0;
    repeat (2) @(negedge i_sys_clk);
    chk({7'h00, o_timer_irq}, 8'h00);
    i_timer_irq_enable = 1'b1;
    repeat (20) @(negedge i_sys_clk);
    rd(8'h91);
    chk(rd_v, 8'h60);
    wr(8'h91, 8'h00);
    // Split mode with the high byte stopped, then running.
    wr(8'h92, 8'h80);
    wr(8'h94, 8'hF0);
    wr(8'h95, 8'h55);
    wr(8'h91, 8'h08);
    poll(6);
    chk(rd_v, 8'h48);
    rd(8'h95);
    chk(rd_v, 8'h55);
    rd(8'h94);
    inr(rd_v, 8'h80, 8'h8F);
    wr(8'h93, 8'h40);
    wr(8'h95, 8'hF8);
    wr(8'h91, 8'h0C);
    poll(7);
    wr(8'h91, 8'h08);
    rd(8'h95);
    inr(rd_v, 8'h40, 8'h4F);
    wr(8'h91, 8'h00);
    // Divided sources.
    i_high_byte_clock_select = 1'b0;
    i_low_byte_clock_select = 1'b0;
    wr(8'h94, 8'h00);
    wr(8'h95, 8'h00);
    wr(8'h91, 8'h04);
    repeat (240) @(negedge i_sys_clk);
    wr(8'h91, 8'h00);
    rd(8'h94);
    inr(rd_v, 8'h13, 8'h15);
    wr(8'h94, 8'h00);
    wr(8'h91, 8'h05);
    repeat (640) @(negedge i_sys_clk);
    wr(8'h91, 8'h00);
    rd(8'h94);
    inr(rd_v, 8'h09, 8'h0B);
    i_high_byte_clock_select = 1'b1;
    wr(8'h94, 8'h00);
    wr(8'h95, 8'h00);
    wr(8'h91, 8'h0D);
    repeat (128) @(negedge i_sys_clk);
    wr(8'h91, 8'h00);
    rd(8'h95);
    inr(rd_v, 8'h7E, 8'h83);
    rd(8'h94);
    inr(rd_v, 8'h01, 8'h03);
    // Capture: two events one divided period apart.
    i_low_byte_clock_select = 1'b1;
    wr(8'h91, 8'h14);
    poll(7);
    rd(8'h92);
    cap_a[7:0] = rd_v;
    rd(8'h93);
    cap_a[15:8] = rd_v;
    wr(8'h91, 8'h14);
    rd(8'h91);
    chk(rd_v, 8'h14);
    poll(7);
    rd(8'h92);
    cap_d[7:0] = rd_v;
    rd(8'h93);
    cap_d[15:8] = rd_v;
    cap_d = cap_d - cap_a;
    chk(cap_d[7:0], 8'h40);
    chk(cap_d[15:8], 8'h00);
    // Reset in mid-run, with the high flag set and capture running.
    @(negedge i_sys_clk);
    i_rst = 1'b1;
    repeat (2) @(negedge i_sys_clk);
    i_rst = 1'b0;
    chk({7'h00, o_timer_irq}, 8'h00);
    for (int a = 8'h91; a <= 8'h95; a++) begin
      rd(8'(a));
      chk(rd_v, 8'h00);
    end
    finish_test();
  end
endmodule : testbench
